// File: sar_pkg.sv
// shared constants, types and register map of the converter control block
package sar_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLKDIV = 8'h04;
  localparam logic [7:0] OFS_REF = 8'h08;
  localparam logic [7:0] OFS_CHAN = 8'h0C;
  localparam logic [7:0] OFS_TIMER = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_PREV = 8'h18;
  localparam logic [7:0] OFS_THRESH = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  // control register bit positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_RJ = 3;
  localparam int CTRL_RC = 4;
  localparam int CTRL_PIE = 5;
  localparam int CTRL_GIE = 6;
  // reference register: positive select in [2:0], negative select bit
  localparam int REF_NREF = 4;
  // timer register: acquisition in [7:0], precharge in [15:8]
  localparam int TIMER_PRE = 8;
  // status / mask bit positions
  localparam int ST_DONE = 0;
  localparam int ST_THR = 1;
  // positive reference codes
  localparam logic [2:0] PREF_PIN = 3'h0;
  localparam logic [2:0] PREF_SUPPLY = 3'h1;
  localparam logic [2:0] PREF_FIX1 = 3'h2;
  localparam logic [2:0] PREF_FIX2 = 3'h3;
  localparam logic [2:0] PREF_FIX4 = 3'h4;
  // conversion timing in half converter clock periods
  localparam logic [4:0] CONV_LAST = 5'h16;
  localparam logic [4:0] DEC_FIRST = 5'h03;
  localparam logic [4:0] DEC_LAST = 5'h15;
  localparam logic [9:0] SAR_MSB = 10'h200;
  // reset values
  localparam logic [5:0] RST_DIV = 6'h00;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [9:0] RST_THRESH = 10'h3FF;
  localparam logic [5:0] RST_CHAN = 6'h00;

  typedef enum logic [1:0] {SAR_IDLE, SAR_PRE, SAR_ACQ, SAR_CONV} sar_state_t;

  // software control bits
  typedef struct packed {
    logic global_irq_enable;
    logic pie;
    logic rc_sel;
    logic right_just;
    logic cont;
    logic en;
  } sar_cfg_t;

  // analog front end selections
  typedef struct packed {
    logic [5:0] channel;
    logic [2:0] pref;
    logic nref;
  } sar_ana_t;
endpackage : sar_pkg

// File: sar_sync.sv
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sar_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read only by the second
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule : sar_sync
`default_nettype wire

// File: sar_tad_gen.sv
// converter clock half-period strobe: divided system clock or rc oscillator
`timescale 1ns/1ps
`default_nettype none
module sar_tad_gen (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic rc_sel_i,
  input wire logic [5:0] div_i,
  input wire logic rc_lvl_i,
  output logic half_o
);
  logic [5:0] cnt_ff;
  logic rc_prev_ff;

  // each half period lasts n+1 system clocks, so a full one lasts 2*(n+1)
  assign half_o = rc_sel_i ? (rc_lvl_i != rc_prev_ff) : (cnt_ff == div_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 6'h00;
    end else if (rc_sel_i || half_o || cnt_ff > div_i) begin
      cnt_ff <= 6'h00; // a shrunk divider restarts rather than wrapping
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // each rc edge, rising or falling, marks one half period
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rc_prev_ff <= 1'b0;
    end else begin
      rc_prev_ff <= rc_lvl_i;
    end
  end

  div_gap_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (half_o && !rc_sel_i && div_i == 6'h02 && $stable(div_i)) |=>
    !half_o ##1 !half_o ##1 (half_o || div_i != 6'h02))
    else $error("divider half period wrong");
endmodule : sar_tad_gen
`default_nettype wire

// File: sar_converter_control.sv
// 10-bit successive approximation converter control with wishbone registers
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sar_converter_control (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rc_osc_i,
  input wire logic cmp_i,
  input wire logic sleep_i,
  output sar_pkg::sar_ana_t ana_o,
  output logic precharge_o,
  output logic sample_o,
  output logic [9:0] trial_o,
  output logic irq_o,
  output logic wake_o,
  output logic vector_o
);
  sar_pkg::sar_state_t st_ff;
  sar_pkg::sar_cfg_t cfg_ff;
  sar_pkg::sar_ana_t sel_ff;
  sar_pkg::sar_ana_t ana_ff;
  logic go_ff;
  logic [5:0] div_ff;
  logic [7:0] acq_ff;
  logic [7:0] pre_ff;
  logic [7:0] cnt_ff;
  logic [9:0] thr_ff;
  logic [9:0] sar_ff;
  logic [9:0] mask_ff;
  logic [9:0] res_ff;
  logic [9:0] prev_ff;
  logic [4:0] hcnt_ff;
  logic ph_ff;
  logic [1:0] stat_ff;
  logic [1:0] imask_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic [1:0] sync_q;
  logic half_raw;
  logic half;
  logic tad;
  logic run_ok;
  logic start;
  logic done;
  logic thr_hit;
  logic req;
  logic wr;
  logic [31:0] wmask;

  // merge written byte lanes into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // place the 10-bit value in the 16-bit pair; left justify leaves six zeros below
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic rj);
    fmt = rj ? {6'h00, r} : {r, 6'h00};
  endfunction : fmt

  // rc oscillator and comparator come from outside this clock domain
  sar_sync #(.W(2)) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i({rc_osc_i, cmp_i}),
    .q_o(sync_q)
  );

  sar_tad_gen u_tad (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .rc_sel_i(cfg_ff.rc_sel),
    .div_i(div_ff),
    .rc_lvl_i(sync_q[1]),
    .half_o(half_raw)
  );

  // with the divided system clock the sequencer stops while asleep (analog selections still follow); a go waits
  assign run_ok = !sleep_i || cfg_ff.rc_sel;
  assign half = half_raw && run_ok;
  assign tad = half && ph_ff;
  assign start = (st_ff == sar_pkg::SAR_IDLE) && half && cfg_ff.en && go_ff;
  // go or enable cleared in the last half must not post a result or a flag
  assign done = (st_ff == sar_pkg::SAR_CONV) && half && hcnt_ff == sar_pkg::CONV_LAST &&
                go_ff && cfg_ff.en;
  assign thr_hit = done && (sar_ff >= thr_ff);

  // bus decode
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // single-cycle answer: ack one cycle after the request, then low for a cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      dat_ff <= req ? nxt_dat : 32'h0000_0000;
    end
  end

  // read mux; unmapped offsets read as zero and still acknowledge
  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      sar_pkg::OFS_CTRL: nxt_dat = 32'({cfg_ff.global_irq_enable, cfg_ff.pie, cfg_ff.rc_sel,
                                        cfg_ff.right_just, cfg_ff.cont, go_ff, cfg_ff.en});
      sar_pkg::OFS_CLKDIV: nxt_dat = 32'(div_ff);
      sar_pkg::OFS_REF: nxt_dat = 32'({sel_ff.nref, 1'b0, sel_ff.pref});
      sar_pkg::OFS_CHAN: nxt_dat = 32'(sel_ff.channel);
      sar_pkg::OFS_TIMER: nxt_dat = 32'({pre_ff, acq_ff});
      sar_pkg::OFS_RESULT: nxt_dat = 32'(fmt(res_ff, cfg_ff.right_just));
      sar_pkg::OFS_PREV: nxt_dat = 32'(fmt(prev_ff, cfg_ff.right_just));
      sar_pkg::OFS_THRESH: nxt_dat = 32'(thr_ff);
      sar_pkg::OFS_STATUS: nxt_dat = 32'(stat_ff);
      sar_pkg::OFS_MASK: nxt_dat = 32'(imask_ff);
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  // configuration registers written by software
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ff <= '0;
      div_ff <= sar_pkg::RST_DIV;
      sel_ff <= '{channel: sar_pkg::RST_CHAN, pref: sar_pkg::PREF_PIN, nref: 1'b0};
      acq_ff <= sar_pkg::RST_TIMER;
      pre_ff <= sar_pkg::RST_TIMER;
      thr_ff <= sar_pkg::RST_THRESH;
      imask_ff <= 2'h0;
    end else if (wr) begin
      case (wb_adr_i)
        sar_pkg::OFS_CTRL: if (wb_sel_i[0]) begin
          cfg_ff.en <= wb_dat_i[sar_pkg::CTRL_EN];
          cfg_ff.cont <= wb_dat_i[sar_pkg::CTRL_CONT];
          cfg_ff.right_just <= wb_dat_i[sar_pkg::CTRL_RJ];
          cfg_ff.rc_sel <= wb_dat_i[sar_pkg::CTRL_RC];
          cfg_ff.pie <= wb_dat_i[sar_pkg::CTRL_PIE];
          cfg_ff.global_irq_enable <= wb_dat_i[sar_pkg::CTRL_GIE];
        end
        sar_pkg::OFS_CLKDIV: div_ff <= 6'(merge(32'(div_ff), wb_dat_i, wmask));
        sar_pkg::OFS_REF: if (wb_sel_i[0]) begin
          sel_ff.pref <= wb_dat_i[2:0];
          sel_ff.nref <= wb_dat_i[sar_pkg::REF_NREF];
        end
        sar_pkg::OFS_CHAN: sel_ff.channel <= 6'(merge(32'(sel_ff.channel), wb_dat_i, wmask));
        sar_pkg::OFS_TIMER: begin
          acq_ff <= 8'(merge(32'(acq_ff), wb_dat_i, wmask));
          pre_ff <= 8'(merge(32'(pre_ff), wb_dat_i >> sar_pkg::TIMER_PRE,
                             wmask >> sar_pkg::TIMER_PRE));
        end
        sar_pkg::OFS_THRESH: thr_ff <= 10'(merge(32'(thr_ff), wb_dat_i, wmask));
        sar_pkg::OFS_MASK: imask_ff <= 2'(merge(32'(imask_ff), wb_dat_i, wmask));
        default: ;
      endcase
    end
  end

  // go: software sets or clears it; hardware clears it at the end unless continuous
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      go_ff <= 1'b0;
    end else if (wr && wb_adr_i == sar_pkg::OFS_CTRL && wb_sel_i[0]) begin
      go_ff <= wb_dat_i[sar_pkg::CTRL_GO]; // a software write wins over the end
    end else if (done && !cfg_ff.cont) begin
      go_ff <= 1'b0;
    end
  end

  // sticky status, write one to clear; a same-cycle event wins over the clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_ff <= 2'h0;
    end else begin
      stat_ff <= (stat_ff & ~((wr && wb_adr_i == sar_pkg::OFS_STATUS) ?
                  (wb_dat_i[1:0] & wmask[1:0]) : 2'h0))
                 | {thr_hit, done};
    end
  end

  // analog selections change only on a converter clock edge, so rc writes lag
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ana_ff <= '{channel: sar_pkg::RST_CHAN, pref: sar_pkg::PREF_PIN, nref: 1'b0};
    end else if (half_raw) begin
      ana_ff <= sel_ff;
    end
  end

  // half-period phase; a full converter clock period ends on every second half
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_ff <= 1'b0;
    end else if (start) begin
      ph_ff <= 1'b0;
    end else if (half) begin
      ph_ff <= !ph_ff;
    end
  end

  // sequencer: precharge, acquisition, then 23 half periods of approximation
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= sar_pkg::SAR_IDLE;
      cnt_ff <= sar_pkg::RST_TIMER;
      hcnt_ff <= 5'h00;
    end else if (!cfg_ff.en || (!go_ff && st_ff != sar_pkg::SAR_IDLE)) begin
      st_ff <= sar_pkg::SAR_IDLE; // turned off or aborted by software
    end else begin
      unique case (st_ff)
        sar_pkg::SAR_IDLE: if (start) begin
          st_ff <= sar_pkg::SAR_PRE;
          cnt_ff <= pre_ff;
        end
        sar_pkg::SAR_PRE: if (tad) begin
          if (cnt_ff == 8'h00) begin
            st_ff <= sar_pkg::SAR_ACQ;
            cnt_ff <= acq_ff;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        sar_pkg::SAR_ACQ: if (tad) begin
          if (cnt_ff == 8'h00) begin
            st_ff <= sar_pkg::SAR_CONV;
            hcnt_ff <= 5'h00;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        sar_pkg::SAR_CONV: if (half) begin
          if (done) begin
            st_ff <= sar_pkg::SAR_IDLE;
          end else begin
            hcnt_ff <= hcnt_ff + 5'h01;
          end
        end
      endcase
    end
  end

  // trial register: keep or drop the bit under test, then try the next one
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sar_ff <= 10'h000;
      mask_ff <= 10'h000;
    end else if (st_ff == sar_pkg::SAR_ACQ) begin
      sar_ff <= sar_pkg::SAR_MSB;
      mask_ff <= sar_pkg::SAR_MSB;
    end else if (st_ff == sar_pkg::SAR_CONV && half && hcnt_ff[0] &&
                 hcnt_ff >= sar_pkg::DEC_FIRST && hcnt_ff <= sar_pkg::DEC_LAST) begin
      sar_ff <= (sync_q[0] ? sar_ff : (sar_ff & ~mask_ff)) | (mask_ff >> 1);
      mask_ff <= mask_ff >> 1;
    end
  end

  // result pair and previous result are updated together at the end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_ff <= 10'h000;
      prev_ff <= 10'h000;
    end else if (done) begin
      res_ff <= sar_ff;
      prev_ff <= res_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign ana_o = ana_ff;
  assign trial_o = sar_ff;
  assign precharge_o = (st_ff == sar_pkg::SAR_PRE);
  assign sample_o = (st_ff == sar_pkg::SAR_ACQ);
  // level interrupt; wake only while asleep, vectoring needs both enables
  assign irq_o = |(stat_ff & imask_ff);
  assign wake_o = irq_o && sleep_i;
  assign vector_o = irq_o && cfg_ff.pie && cfg_ff.global_irq_enable;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  bus_ack_a: assert property (s_bus_req |=> s_ack_once)
    else $error("bus ack not a single pulse");
  done_flag_a: assert property (done |=> stat_ff[sar_pkg::ST_DONE])
    else $error("completion flag not set");
  flag_stays_a: assert property (stat_ff[sar_pkg::ST_DONE] && !wr |=> stat_ff[sar_pkg::ST_DONE])
    else $error("completion flag cleared by hardware");
  go_clear_a: assert property (done && !cfg_ff.cont && !wr |=> !go_ff)
    else $error("go not cleared at end");
  go_cont_a: assert property (done && cfg_ff.cont && !wr |=> go_ff)
    else $error("go cleared in continuous mode");
  prev_result_a: assert property (done |=> prev_ff == $past(res_ff) && res_ff == $past(sar_ff))
    else $error("previous result not kept");
  sleep_hold_a: assert property (sleep_i && !cfg_ff.rc_sel && go_ff && cfg_ff.en |=> $stable(st_ff))
    else $error("conversion advanced in sleep");
  conv_len_a: assert property (done |-> hcnt_ff == 5'h16 && mask_ff == 10'h000)
    else $error("conversion length not 23 halves");
  wake_vec_a: assert property (irq_o && sleep_i |-> wake_o ##0 (vector_o == (cfg_ff.pie && cfg_ff.global_irq_enable)))
    else $error("wake or vector wrong");
  thr_flag_a: assert property (done && sar_ff >= thr_ff |=> stat_ff[sar_pkg::ST_THR])
    else $error("threshold flag not set");
  timers_a: assert property (st_ff == sar_pkg::SAR_IDLE ##1 st_ff == sar_pkg::SAR_PRE |-> cnt_ff == $past(pre_ff))
    else $error("precharge timer not loaded");
  ana_tad_a: assert property (!$stable(ana_ff) |-> $past(half_raw))
    else $error("analog selection changed off a converter edge");
endmodule : sar_converter_control
`default_nettype wire

// File: sar_afe_model.sv
// behavioural analog front end: channel sources, sample-and-hold, comparator
`timescale 1ns/1ps
`default_nettype none
module sar_afe_model (
  input wire logic ref_clk_i,
  input wire sar_pkg::sar_ana_t ana_i,
  input wire logic sample_i,
  input wire logic [9:0] trial_i,
  output logic cmp_o
);
  logic [9:0] held = 10'h000;
  logic [9:0] src;
  // each channel carries its own level, so a wrong route shows in the result
  assign src = {4'h0, ana_i.channel} * 10'h00D + 10'h005;
  // the hold capacitor follows the source only while sampling
  always_ff @(posedge ref_clk_i) begin
    if (sample_i) begin
      held <= src;
    end
  end
  // keep the trial bit while the held level is at or above it
  assign cmp_o = (held >= trial_i);
endmodule : sar_afe_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] EN = 32'h0000_0001 << sar_pkg::CTRL_EN;
  localparam logic [31:0] GO = 32'h0000_0001 << sar_pkg::CTRL_GO;
  localparam logic [31:0] CONT = 32'h0000_0001 << sar_pkg::CTRL_CONT;
  localparam logic [31:0] RJ = 32'h0000_0001 << sar_pkg::CTRL_RJ;
  localparam logic [31:0] RC = 32'h0000_0001 << sar_pkg::CTRL_RC;
  localparam logic [31:0] IE = (32'h0000_0001 << sar_pkg::CTRL_PIE) |
                               (32'h0000_0001 << sar_pkg::CTRL_GIE);
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic rc_osc = 1'b0;
  logic sleep = 1'b0;
  logic cmp;
  sar_pkg::sar_ana_t ana;
  logic precharge;
  logic smp;
  logic [9:0] trial;
  logic irq;
  logic wake;
  logic vec;
  logic [31:0] rd;
  int err_count = 0;
  int compares = 0;

  sar_converter_control i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rc_osc_i(rc_osc),
    .cmp_i(cmp), .sleep_i(sleep), .ana_o(ana), .precharge_o(precharge), .sample_o(smp),
    .trial_o(trial), .irq_o(irq), .wake_o(wake), .vector_o(vec));
  sar_afe_model i_afe (.ref_clk_i(ref_clk_i), .ana_i(ana), .sample_i(smp), .trial_i(trial),
    .cmp_o(cmp));

  // system clock; the rc oscillator runs free at an unrelated period
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    forever #97.3 rc_osc = ~rc_osc;
  end

  function automatic logic [9:0] lvl(input logic [5:0] ch);
    return {4'h0, ch} * 10'h00D + 10'h005;
  endfunction : lvl

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    compares++;
    if (got !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : check

  // one classic cycle: request held until ack is sampled, then released
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_wdat <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    check("bus ack", 32'h0000_0001, {31'h0, wb_ack});
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0000_0000);
    check($sformatf("register %h", a), e, rd);
  endtask : rd_chk

  // poll status; a flag that never rises fails the final compare
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[sar_pkg::ST_DONE] !== 1'b1 && n < lim) begin
      wb_xfer(1'b0, sar_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end
    check("done flag", 32'h0000_0001, {31'h0, rd[sar_pkg::ST_DONE]});
  endtask : wait_done

  task automatic t_reset();
    rd_chk(sar_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk(sar_pkg::OFS_CLKDIV, 32'h0000_0000);
    rd_chk(sar_pkg::OFS_THRESH, 32'h0000_03FF);
    rd_chk(sar_pkg::OFS_STATUS, 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rd_chk(8'h30, 32'h0000_0000);
    wr(sar_pkg::OFS_RESULT, 32'h0000_FFFF);
    rd_chk(sar_pkg::OFS_RESULT, 32'h0000_0000);
  endtask : t_reset

  // selections must reach the front end within 8 system clocks, under three converter half periods
  task automatic t_front();
    sar_pkg::sar_ana_t e;
    wr(sar_pkg::OFS_CLKDIV, 32'h0000_0002);
    for (int p = 0; p < 5; p++) begin
      e = {6'(p * 9), 3'(p), p[0]};
      wr(sar_pkg::OFS_CHAN, {26'h0, e.channel});
      wr(sar_pkg::OFS_REF, {27'h0, e.nref, 1'b0, e.pref});
      repeat (8) @(posedge ref_clk_i);
      check("analog selection", {22'h0, e}, {22'h0, ana});
    end
  endtask : t_front

  task automatic t_timing(input logic [5:0] dv, input logic [7:0] pre, input logic [7:0] acq);
    int n;
    int h;
    int e;
    int np;
    int ns;
    h = int'(dv) + 1;
    e = (2 * (int'(pre) + int'(acq) + 2) + 23) * h;
    wr(sar_pkg::OFS_CLKDIV, {26'h0, dv});
    wr(sar_pkg::OFS_TIMER, {16'h0, pre, acq});
    wr(sar_pkg::OFS_MASK, 32'h0000_0001);
    wr(sar_pkg::OFS_CHAN, 32'h0000_0009);
    wr(sar_pkg::OFS_CTRL, EN | RJ);
    wr(sar_pkg::OFS_CTRL, EN | GO | RJ);
    n = 0;
    np = 0;
    ns = 0;
    // timer phases are counted in system clocks: value+1 converter periods each
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
      np += int'(precharge === 1'b1);
      ns += int'(smp === 1'b1);
    end
    check("done latency in range", 32'h1, 32'(n >= e - 1 && n <= e + h + 3));
    check("precharge cycles", 32'(2 * (int'(pre) + 1) * h), 32'(np));
    check("sample cycles", 32'(2 * (int'(acq) + 1) * h), 32'(ns));
    rd_chk(sar_pkg::OFS_RESULT, {22'h0, lvl(6'h09)});
    rd_chk(sar_pkg::OFS_CTRL, EN | RJ);
    repeat (40) @(posedge ref_clk_i);
    wr(sar_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk(sar_pkg::OFS_STATUS, 32'h0000_0001);
    wr(sar_pkg::OFS_STATUS, 32'h0000_0001);
    @(posedge ref_clk_i);
    check("irq after clear", 32'h0, {31'h0, irq});
  endtask : t_timing

  task automatic convert(input logic [5:0] ch, input logic [31:0] mode, input logic [9:0] thr);
    logic [31:0] e;
    e = mode[sar_pkg::CTRL_RJ] ? {22'h0, lvl(ch)} : {16'h0, lvl(ch), 6'h00};
    wr(sar_pkg::OFS_CHAN, {26'h0, ch});
    wr(sar_pkg::OFS_THRESH, {22'h0, thr});
    wr(sar_pkg::OFS_CTRL, EN | mode);
    wr(sar_pkg::OFS_CTRL, EN | GO | mode);
    wait_done(400);
    check("threshold flag", {31'h0, lvl(ch) >= thr}, {31'h0, rd[sar_pkg::ST_THR]});
    rd_chk(sar_pkg::OFS_RESULT, e);
    wb_xfer(1'b0, sar_pkg::OFS_CTRL, 32'h0000_0000);
    check("go after end", {31'h0, mode[sar_pkg::CTRL_CONT]}, {31'h0, rd[1]});
    wr(sar_pkg::OFS_STATUS, 32'h0000_0003);
  endtask : convert

  task automatic t_results();
    wr(sar_pkg::OFS_MASK, 32'h0000_0000);
    convert(6'h14, RJ, 10'h3FF);
    convert(6'h2A, RJ, lvl(6'h2A));
    rd_chk(sar_pkg::OFS_PREV, {22'h0, lvl(6'h14)});
    convert(6'h3F, 32'h0000_0000, 10'h000);
    convert(6'h05, CONT | RJ, 10'h3FF);
    wait_done(400);
    wr(sar_pkg::OFS_CTRL, EN | RJ);
    wr(sar_pkg::OFS_STATUS, 32'h0000_0003);
    repeat (200) @(posedge ref_clk_i);
    rd_chk(sar_pkg::OFS_STATUS, 32'h0000_0000);
  endtask : t_results

  task automatic t_sleep();
    int n;
    wr(sar_pkg::OFS_MASK, 32'h0000_0001);
    sleep <= 1'b1;
    wr(sar_pkg::OFS_CTRL, EN | GO | RJ);
    repeat (300) @(posedge ref_clk_i);
    check("irq asleep on system clock", 32'h0, {31'h0, irq});
    sleep <= 1'b0;
    wait_done(400);
    wr(sar_pkg::OFS_STATUS, 32'h0000_0003);
    // the rc clock keeps converting in sleep and the done flag wakes the device
    wr(sar_pkg::OFS_CTRL, EN | RC | RJ);
    sleep <= 1'b1;
    wr(sar_pkg::OFS_CTRL, EN | RC | GO | RJ);
    n = 0;
    while (wake !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    check("wake", 32'h1, {31'h0, wake});
    check("vector without enables", 32'h0, {31'h0, vec});
    wr(sar_pkg::OFS_CTRL, EN | RC | RJ | IE);
    @(posedge ref_clk_i);
    check("vector with enables", 32'h1, {31'h0, vec});
    wr(sar_pkg::OFS_STATUS, 32'h0000_0003);
    @(posedge ref_clk_i);
    check("wake after clear", 32'h0, {31'h0, wake});
    sleep <= 1'b0;
  endtask : t_sleep

  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // watchdog sized well above the expected run of a few thousand cycles
  initial begin
    #(25 * 40000);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_front();
    t_timing(6'h02, 8'h01, 8'h02);
    t_timing(6'h04, 8'h00, 8'h00);
    t_results();
    t_sleep();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
